/* hdl/irqpm_cfg.svh */
// constants for the interrupt priority and power mode block
// assumes a 32-bit AXI4-Lite register bus, byte addresses
`ifndef IRQPM_CFG_SVH
`define IRQPM_CFG_SVH
// register indices, byte address is index times four
`define IDX_POWER_CONTROL   8'h87
`define IDX_PRIO_A          8'hF6
`define IDX_PRIO_B          8'hF7
`define IDX_PM_STATUS       8'hF8
`define ADDR_W              12
`define RST_BYTE            8'h00
`define PRIO_B_MASK         8'h5F
`define PC_STOP_BIT         1
`define PC_IDLE_BIT         0
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`define RESET_VECTOR        20'h00000
`define MCD_TIMEOUT_NS      100000
`define CLK_PERIOD_NS       40
`endif

/* hdl/irqpm_pkg.sv */
// types for the interrupt priority and power mode block
// assumes irqpm_cfg.svh supplies the numeric constants
package irqpm_pkg;
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_STOP} pm_state_t;
  typedef struct packed {
    logic [7:0] prio_a;
    logic [7:0] prio_b;
  } prio_t;
endpackage : irqpm_pkg

/* hdl/irqpm_top.sv */
// interrupt priority registers and idle/stop power mode control
// assumes an AXI4-Lite master, core instruction-complete strobe, sync reset
//
// Behaviour
// - priority A at 0xF6, all pages, resets zero, one means high priority.
// - priority A bits 7..4: cmp1 rise, cmp1 fall, cmp0 rise, cmp0 fall.
// - priority A bits 3..0: counter array, conv0 window, two-wire, serial periph.
// - priority B at 0xF7, resets zero; bits 7 and 5 read zero, ignore writes.
// - priority B bit 6 uart b, bit 4 conv2 eoc, bit 3 conv2 window.
// - priority B bit 2 timer four, bit 1 conv0 eoc, bit 0 timer three.
// - idle bit write halts processor once writing instruction completes.
// - idle keeps state and peripheral clocks; only processor clock gated.
// - enabled interrupt or reset ends idle, processor resumes and services it.
// - after return, execution continues after the idle-setting instruction.
// - reset ending idle runs normal reset sequence from address zero.
// - unserviced watchdog reset eventually ends idle mode.
// - stop bit write stops processor and oscillators after instruction completes.
// - only reset ends stop; restart at address zero.
// - missing clock detector reset ends stop; disable it beyond 100 us.
// - power control at 0x87, all pages, resets zero, upper bits reserved.
// - stop and idle bits act on writing one and read as zero.
`timescale 1ns/1ps
`include "irqpm_cfg.svh"

module irqpm_top (
  // clock and reset
  input  wire logic                      MCLK_IN,
  input  wire logic                      NRST_IN,
  // axi4-lite write address and data
  input  wire logic [`ADDR_W-1:0]        AWADDR_IN,
  input  wire logic                      AWVALID_IN,
  output logic                           AWREADY_OUT,
  input  wire logic [31:0]               WDATA_IN,
  input  wire logic [3:0]                WSTRB_IN,
  input  wire logic                      WVALID_IN,
  output logic                           WREADY_OUT,
  // axi4-lite write response
  output logic [1:0]                     BRESP_OUT,
  output logic                           BVALID_OUT,
  input  wire logic                      BREADY_IN,
  // axi4-lite read
  input  wire logic [`ADDR_W-1:0]        ARADDR_IN,
  input  wire logic                      ARVALID_IN,
  output logic                           ARREADY_OUT,
  output logic [31:0]                    RDATA_OUT,
  output logic [1:0]                     RRESP_OUT,
  output logic                           RVALID_OUT,
  input  wire logic                      RREADY_IN,
  // core side
  input  wire logic                      INSTR_DONE_IN,
  input  wire logic                      IRQ_ENABLED_IN,
  input  wire logic                      WDT_RESET_IN,
  input  wire logic                      MCD_RESET_IN,
  output irqpm_pkg::prio_t               PRIO_OUT,
  output logic                           CPU_CLK_EN_OUT,
  output logic                           OSC_EN_OUT,
  output logic                           IDLE_WAKE_OUT,
  output logic                           CORE_RESET_OUT,
  output logic [19:0]                    RESET_VECTOR_OUT
);
  import irqpm_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers (peripheral and reset sources are asynchronous)
  // ----------------------------------------------------------------
  wire [2:0] async_in = {MCD_RESET_IN, WDT_RESET_IN, IRQ_ENABLED_IN};
  wire [2:0] sync_out;
  // one two-stage chain per source; only the second stage is read
  for (genvar g = 0; g < 3; g++) begin : g_sync
    logic [1:0] stage_q;
    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        stage_q <= 2'h0;
      end else begin
        stage_q <= {stage_q[0], async_in[g]};
      end
    end
    assign sync_out[g] = stage_q[1];
  end
  wire irq_sync = sync_out[0];
  // internal resets from watchdog and missing clock detector
  wire int_rst  = sync_out[1] | sync_out[2];

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic                 aw_hold_q;
  logic                 w_hold_q;
  logic [`ADDR_W-1:0]   awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  wire aw_hs = AWVALID_IN & AWREADY_OUT;
  wire w_hs  = WVALID_IN & WREADY_OUT;
  wire aw_ok = aw_hold_q | aw_hs;
  wire w_ok  = w_hold_q | w_hs;
  wire wr_go = aw_ok & w_ok & ~BVALID_OUT;
  wire [`ADDR_W-1:0] wa = aw_hold_q ? awaddr_q : AWADDR_IN;
  wire [31:0]        wd = w_hold_q ? wdata_q : WDATA_IN;
  wire [3:0]         ws = w_hold_q ? wstrb_q : WSTRB_IN;
  wire [`ADDR_W-3:0] widx = wa[`ADDR_W-1:2];
  wire               wlane = ws[0];

  // address half of a write waits here for the data half
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end else if (aw_hs) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= AWADDR_IN;
    end
  end

  // data half of a write waits here for the address half
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      w_hold_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end else if (w_hs) begin
      w_hold_q <= 1'b1;
      wdata_q  <= WDATA_IN;
      wstrb_q  <= WSTRB_IN;
    end
  end

  // one-cycle ready pulses; accept each channel once per write
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      AWREADY_OUT <= 1'b0;
    end else begin
      AWREADY_OUT <= ~AWREADY_OUT & ~aw_hold_q & ~BVALID_OUT
                   & AWVALID_IN & ~wr_go;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      WREADY_OUT <= 1'b0;
    end else begin
      WREADY_OUT <= ~WREADY_OUT & ~w_hold_q & ~BVALID_OUT
                  & WVALID_IN & ~wr_go;
    end
  end

  wire wr_known = (widx == 10'(`IDX_POWER_CONTROL)) | (widx == 10'(`IDX_PRIO_A))
                | (widx == 10'(`IDX_PRIO_B)) | (widx == 10'(`IDX_PM_STATUS));

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      BVALID_OUT <= 1'b0;
    end else if (wr_go) begin
      BVALID_OUT <= 1'b1;
    end else if (BREADY_IN) begin
      BVALID_OUT <= 1'b0;
    end
  end

  // unmapped addresses answer with an error and the write is dropped
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      BRESP_OUT <= `RESP_OKAY;
    end else if (wr_go) begin
      BRESP_OUT <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // priority registers
  // ----------------------------------------------------------------
  // bit order a: cmp1 rise, cmp1 fall, cmp0 rise, cmp0 fall, counter array,
  // conv0 window, two-wire, serial periph (msb to lsb)
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      PRIO_OUT.prio_a <= `RST_BYTE;
    end else if (wr_go && wlane && widx == 10'(`IDX_PRIO_A)) begin
      PRIO_OUT.prio_a <= wd[7:0];
    end
  end

  // bit order b: unused, uart b, unused, conv2 eoc, conv2 window,
  // timer four, conv0 eoc, timer three
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      PRIO_OUT.prio_b <= `RST_BYTE;
    end else if (wr_go && wlane && widx == 10'(`IDX_PRIO_B)) begin
      PRIO_OUT.prio_b <= wd[7:0] & `PRIO_B_MASK;
    end
  end

  // ----------------------------------------------------------------
  // power mode control
  // ----------------------------------------------------------------
  // mode bits are write-one triggers; no storage, so they read zero
  wire pc_wr   = wr_go & wlane & (widx == 10'(`IDX_POWER_CONTROL));
  wire req_stp = pc_wr & wd[`PC_STOP_BIT];
  wire req_idl = pc_wr & wd[`PC_IDLE_BIT];

  pm_state_t state_q;
  pm_state_t state_d;
  logic      pend_idle_q;
  logic      pend_stop_q;

  // request waits for the writing instruction to finish
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN || int_rst) begin
      pend_idle_q <= 1'b0;
      pend_stop_q <= 1'b0;
    end else if (state_q != PM_RUN) begin
      pend_idle_q <= 1'b0;
      pend_stop_q <= 1'b0;
    end else begin
      if (req_stp) pend_stop_q <= 1'b1;
      if (req_idl) pend_idle_q <= 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      PM_RUN: begin
        if (INSTR_DONE_IN && pend_stop_q) begin
          state_d = PM_STOP;
        end else if (INSTR_DONE_IN && pend_idle_q) begin
          state_d = PM_IDLE;
        end
      end
      PM_IDLE: begin
        if (irq_sync) begin
          state_d = PM_RUN;
        end
      end
      // only a reset leaves stop
      PM_STOP: state_d = PM_STOP;
      default: state_d = PM_RUN;
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN || int_rst) begin
      state_q <= PM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // core-facing outputs
  // ----------------------------------------------------------------
  wire to_idle = (state_q == PM_RUN) & INSTR_DONE_IN & pend_idle_q & ~pend_stop_q;
  wire to_stop = (state_q == PM_RUN) & INSTR_DONE_IN & pend_stop_q;
  wire wake    = (state_q == PM_IDLE) & irq_sync;

  // idle gates only the processor clock; peripherals keep running
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN || int_rst) begin
      CPU_CLK_EN_OUT <= 1'b1;
    end else begin
      CPU_CLK_EN_OUT <= ~(to_idle | to_stop) & (CPU_CLK_EN_OUT | wake);
    end
  end

  // oscillator comes back only through a reset
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN || int_rst) begin
      OSC_EN_OUT <= 1'b1;
    end else begin
      OSC_EN_OUT <= OSC_EN_OUT & ~to_stop;
    end
  end

  // core takes the interrupt; its return address is the next instruction
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN || int_rst) begin
      IDLE_WAKE_OUT <= 1'b0;
    end else begin
      IDLE_WAKE_OUT <= wake;
    end
  end

  // core reset request; the core restarts at the reset vector
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      CORE_RESET_OUT <= 1'b1;
    end else begin
      CORE_RESET_OUT <= int_rst;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      RESET_VECTOR_OUT <= `RESET_VECTOR;
    end else begin
      RESET_VECTOR_OUT <= `RESET_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire [`ADDR_W-3:0] ridx = ARADDR_IN[`ADDR_W-1:2];
  logic [7:0] rbyte;
  logic       rhit;
  always_comb begin
    rbyte = 8'h00;
    rhit  = 1'b1;
    case (ridx)
      10'(`IDX_POWER_CONTROL): rbyte = 8'h00;
      10'(`IDX_PRIO_A):        rbyte = PRIO_OUT.prio_a;
      10'(`IDX_PRIO_B):        rbyte = PRIO_OUT.prio_b;
      10'(`IDX_PM_STATUS):     rbyte = {6'h00, state_q == PM_STOP, state_q == PM_IDLE};
      default:                 rhit  = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      ARREADY_OUT <= 1'b0;
    end else begin
      ARREADY_OUT <= ~ARREADY_OUT & ~RVALID_OUT & ARVALID_IN;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      RVALID_OUT <= 1'b0;
    end else if (ARVALID_IN && ARREADY_OUT) begin
      RVALID_OUT <= 1'b1;
    end else if (RREADY_IN) begin
      RVALID_OUT <= 1'b0;
    end
  end

  // data and response are captured once and stand until taken
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= 32'h0000_0000;
      RRESP_OUT <= `RESP_OKAY;
    end else if (ARVALID_IN && ARREADY_OUT) begin
      RDATA_OUT <= {24'h000000, rbyte};
      RRESP_OUT <= rhit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

endmodule : irqpm_top

/* sim/irqpm_checker.sv */
// assertions on the priority registers and power mode outputs
// assumes it is bound onto irqpm_top and sees only its ports
`timescale 1ns/1ps
`include "irqpm_cfg.svh"
module irqpm_checker (
  // clock, reset and read channel
  input wire logic                 MCLK_IN,
  input wire logic                 NRST_IN,
  input wire logic [`ADDR_W-1:0]   ARADDR_IN,
  input wire logic                 ARVALID_IN,
  input wire logic                 ARREADY_OUT,
  input wire logic [31:0]          RDATA_OUT,
  input wire logic                 RVALID_OUT,
  // core side
  input wire logic                 INSTR_DONE_IN,
  input wire logic                 IRQ_ENABLED_IN,
  input wire irqpm_pkg::prio_t     PRIO_OUT,
  input wire logic                 CPU_CLK_EN_OUT,
  input wire logic                 OSC_EN_OUT,
  input wire logic                 IDLE_WAKE_OUT,
  input wire logic                 CORE_RESET_OUT,
  input wire logic [19:0]          RESET_VECTOR_OUT
);
  localparam logic [11:0] PC_ADDR = {2'b00, `IDX_POWER_CONTROL, 2'b00};
  localparam logic [11:0] PB_ADDR = {2'b00, `IDX_PRIO_B, 2'b00};
  logic [11:0] rd_addr_q;

  // read data is matched to the address taken at the read handshake
  always_ff @(posedge MCLK_IN) begin
    if (ARVALID_IN && ARREADY_OUT) begin
      rd_addr_q <= ARADDR_IN;
    end
  end

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);

  prio_b_gaps_a: assert property (!PRIO_OUT.prio_b[7] && !PRIO_OUT.prio_b[5])
    else $error("unused priority bit set");
  reset_vals_a: assert property ($rose(NRST_IN) |-> PRIO_OUT == 16'h0000
    && CORE_RESET_OUT && CPU_CLK_EN_OUT && OSC_EN_OUT) else $error("bad reset state");
  mode_entry_a: assert property ($fell(CPU_CLK_EN_OUT) |->
    $past(INSTR_DONE_IN) || $past(INSTR_DONE_IN, 2)) else $error("clock gated early");
  stop_gate_a: assert property (!OSC_EN_OUT |-> !CPU_CLK_EN_OUT)
    else $error("cpu runs without oscillator");
  wake_cause_a: assert property (IDLE_WAKE_OUT |-> CPU_CLK_EN_OUT && OSC_EN_OUT
    && !$past(CPU_CLK_EN_OUT) && $past(IRQ_ENABLED_IN, 3)) else $error("bad idle wake");
  stop_exit_a: assert property ($rose(OSC_EN_OUT) |-> ##[0:1] CORE_RESET_OUT)
    else $error("stop left without reset");
  vector_a: assert property (RESET_VECTOR_OUT == `RESET_VECTOR)
    else $error("restart address wrong");
  pc_read_a: assert property (RVALID_OUT && rd_addr_q == PC_ADDR |-> RDATA_OUT == 0)
    else $error("power control reads nonzero");
  pb_read_a: assert property (RVALID_OUT && rd_addr_q == PB_ADDR |->
    RDATA_OUT == {24'h0, PRIO_OUT.prio_b & 8'h5F}) else $error("priority b read wrong");

  cover property (IDLE_WAKE_OUT);
  cover property ($fell(OSC_EN_OUT));
  cover property (RVALID_OUT && rd_addr_q == PC_ADDR);
endmodule : irqpm_checker

bind irqpm_top irqpm_checker i_chk (.MCLK_IN, .NRST_IN, .ARADDR_IN, .ARVALID_IN,
  .ARREADY_OUT, .RDATA_OUT, .RVALID_OUT, .INSTR_DONE_IN, .IRQ_ENABLED_IN, .PRIO_OUT,
  .CPU_CLK_EN_OUT, .OSC_EN_OUT, .IDLE_WAKE_OUT, .CORE_RESET_OUT, .RESET_VECTOR_OUT);

/* sim/irqpm_core_model.sv */
// core-side model: instruction completion, interrupt, watchdog and clock detector
// assumes the bench calls its tasks; every change lands just after a rising edge
`timescale 1ns/1ps
module irqpm_core_model (
  // clock
  input  wire logic mclk_in,
  // to the block
  output logic      instr_done_out,
  output logic      irq_out,
  output logic      wdt_rst_out,
  output logic      mcd_rst_out
);
  initial begin
    {instr_done_out, irq_out, wdt_rst_out, mcd_rst_out} = 4'h0;
  end
  // the mode write completes; done is held high for one cycle
  task automatic finish_instr();
    @(posedge mclk_in);
    instr_done_out <= 1'b1;
    @(posedge mclk_in);
    instr_done_out <= 1'b0;
  endtask : finish_instr
  task automatic set_irq(input logic lvl);
    @(posedge mclk_in);
    irq_out <= lvl;
  endtask : set_irq
  // held three edges so the two-stage sync cannot miss it
  // analog parts are taken as already shut down before any stop
  task automatic pulse_reset(input logic from_mcd);
    @(posedge mclk_in);
    mcd_rst_out <= from_mcd;
    wdt_rst_out <= !from_mcd;
    repeat (3) @(posedge mclk_in);
    {mcd_rst_out, wdt_rst_out} <= 2'b00;
  endtask : pulse_reset
endmodule : irqpm_core_model

/* sim/irqpm_top_tb.sv */
// self-checking bench for the priority registers and power modes
// assumes the core model drives the core-side inputs
`timescale 1ns/1ps
`include "irqpm_cfg.svh"
module irqpm_top_tb;
  import irqpm_pkg::*;
  localparam logic [11:0] A_PC = {2'b00, `IDX_POWER_CONTROL, 2'b00};
  localparam logic [11:0] A_PA = {2'b00, `IDX_PRIO_A, 2'b00};
  localparam logic [11:0] A_PB = {2'b00, `IDX_PRIO_B, 2'b00};
  localparam logic [11:0] A_ST = {2'b00, `IDX_PM_STATUS, 2'b00};
  logic        mclk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, done, irq, wdt, missing_clock_detector, cpu_en, osc_en, wake, core_rst;
  logic [11:0] awaddr, araddr;
  logic [3:0]  wstrb;
  logic [3:0]  lanes = 4'hF;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [19:0] vec;
  prio_t       prio;
  int          errors = 0;
  int          total_checks = 0;

  irqpm_top i_dut (.MCLK_IN(mclk), .NRST_IN(nrst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .INSTR_DONE_IN(done),
    .IRQ_ENABLED_IN(irq), .WDT_RESET_IN(wdt), .MCD_RESET_IN(missing_clock_detector), .PRIO_OUT(prio),
    .CPU_CLK_EN_OUT(cpu_en), .OSC_EN_OUT(osc_en), .IDLE_WAKE_OUT(wake),
    .CORE_RESET_OUT(core_rst), .RESET_VECTOR_OUT(vec));
  irqpm_core_model i_core (.mclk_in(mclk), .instr_done_out(done), .irq_out(irq),
    .wdt_rst_out(wdt), .mcd_rst_out(missing_clock_detector));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ------
  // tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wc(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    {aw_ok, w_ok} = 2'b00;
    @(posedge mclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, 24'h0, d, lanes, 3'b111};
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge mclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wc
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rc
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // sequence is a few hundred cycles; the limit leaves ample room
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    finish_test();
  end

  // ------
  // tests
  // ------
  initial begin : main
    logic [7:0] m;
    {nrst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rc(A_PA, 0, `RESP_OKAY);
    rc(A_PB, 0, `RESP_OKAY);
    rc(A_PC, 0, `RESP_OKAY);
    wc(12'h004, 8'hFF, `RESP_SLVERR);
    rc(12'h004, 0, `RESP_SLVERR);
    $display("test reset_and_map done");
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wc(A_PA, m, `RESP_OKAY);
      wc(A_PB, m, `RESP_OKAY);
      rc(A_PA, {24'h0, m}, `RESP_OKAY);
      rc(A_PB, {24'h0, m & 8'h5F}, `RESP_OKAY);
      chk({16'h0, prio}, {16'h0, m, m & 8'h5F});
    end
    lanes = 4'hE;
    wc(A_PA, 8'h33, `RESP_OKAY);
    rc(A_PA, 32'h80, `RESP_OKAY);
    lanes = 4'hF;
    wc(A_PC, 8'hFC, `RESP_OKAY);
    rc(A_PC, 0, `RESP_OKAY);
    $display("test priority_bits done");
    wc(A_PA, 8'hA5, `RESP_OKAY);
    wc(A_PC, 8'h01, `RESP_OKAY);
    rc(A_PC, 0, `RESP_OKAY);
    i_core.finish_instr();
    repeat (2) @(posedge mclk);
    chk({30'h0, cpu_en, osc_en}, 1);
    rc(A_ST, 1, `RESP_OKAY);
    rc(A_PA, 32'hA5, `RESP_OKAY);
    i_core.set_irq(1'b1);
    for (int n = 0; n < 10 && wake !== 1'b1; n++) @(posedge mclk);
    chk({30'h0, cpu_en, wake}, 3);
    i_core.set_irq(1'b0);
    rc(A_ST, 0, `RESP_OKAY);
    wc(A_PC, 8'h01, `RESP_OKAY);
    i_core.finish_instr();
    i_core.pulse_reset(1'b0);
    repeat (2) @(posedge mclk);
    chk({30'h0, cpu_en, core_rst}, 3);
    $display("test idle done");
    for (int k = 2; k < 4; k++) begin
      wc(A_PC, 8'(k), `RESP_OKAY);
      i_core.finish_instr();
      repeat (2) @(posedge mclk);
      rc(A_ST, 2, `RESP_OKAY);
      i_core.set_irq(1'b1);
      repeat (8) @(posedge mclk);
      chk({29'h0, cpu_en, osc_en, wake}, 0);
      i_core.set_irq(1'b0);
      i_core.pulse_reset(1'b1);
      repeat (2) @(posedge mclk);
      chk({9'h0, core_rst, cpu_en, osc_en, vec}, {9'h0, 3'b111, 20'h0});
    end
    wc(A_PC, 8'h01, `RESP_OKAY);
    i_core.finish_instr();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk({31'h0, cpu_en}, 1);
    rc(A_PA, 0, `RESP_OKAY);
    $display("test stop_and_reset done");
    finish_test();
  end
endmodule : irqpm_top_tb
